// ### swg_defines.svh
`ifndef SWG_DEFINES_SVH
`define SWG_DEFINES_SVH
// clock period and sample tick
`define SWG_CLK_NS 10
`define SWG_TICK_NS 10000
`define SWG_TICK_CYC (`SWG_TICK_NS / `SWG_CLK_NS)
// interval limits in ticks, least rounded up, longest rounded down
`define SWG_TMIN_NS 100000
`define SWG_TMAX_S 36000
`define SWG_TMIN_TK ((`SWG_TMIN_NS + `SWG_TICK_NS - 1) / `SWG_TICK_NS)
`define SWG_TMAX_TK ((64'd1000000000 * `SWG_TMAX_S) / `SWG_TICK_NS)
// sine frequency limits and phase step per hertz
`define SWG_FMIN 14'h0001
`define SWG_FMAX 14'h2710
`define SWG_PH_PER_HZ (((64'h1 << 32) * `SWG_TICK_NS) / 64'd1000000000)
// full scale of a set value and repeat limit
`define SWG_NOM 16'hCCCC
`define SWG_REP_MAX 10'h3E7
// register byte offsets
`define SWG_REG_CMD 8'h00
`define SWG_REG_CFG 8'h04
`define SWG_REG_STAT 8'h08
`define SWG_REG_AMPL 8'h0C
`define SWG_REG_OFFS 8'h10
`define SWG_REG_FREQ 8'h14
`define SWG_REG_T1 8'h18
`define SWG_REG_T2 8'h1C
`define SWG_REG_T3 8'h20
`define SWG_REG_T4 8'h24
`define SWG_REG_SETU 8'h28
`define SWG_REG_SETI 8'h2C
`define SWG_REG_SETP 8'h30
`define SWG_REG_REP 8'h34
`define SWG_REG_PAUSE 8'h38
`define SWG_REG_SEG0 8'h40
`define SWG_REG_SEGEND 8'h90
// command and config bit positions
`define SWG_CMD_START 0
`define SWG_CMD_STOP 1
`define SWG_CMD_ONOFF 2
`define SWG_CMD_CLR 3
`define SWG_CFG_TGT 3
// reset values
`define SWG_T_RST 32'h0000000A
`define SWG_F_RST 14'h0001
`define SWG_REP_RST 10'h001
`define SWG_SEG_LO_RST 80'h0BB8_0BB8_0960_0960_1770
`define SWG_SEG_HI_RST 80'h1770_0BB8_0BB8_0960_0960
`define SWG_SEG_T_RST 160'h00002710_00002710_00001388_000005DC_000001F4
`endif

// ### swg_pkg.sv
package swg_pkg;
  // waveform selection
  typedef enum logic [2:0] {
    SWG_SINE = 3'b000,
    SWG_TRI = 3'b001,
    SWG_RECT = 3'b010,
    SWG_TRAP = 3'b011,
    SWG_ENG = 3'b100
  } swg_func_t;
  // set value driven by the wave
  typedef enum logic {SWG_VOLT = 1'b0, SWG_CURR = 1'b1} swg_tgt_t;
  // sequencer states
  typedef enum logic [1:0] {SWG_IDLE = 2'b00, SWG_RUN = 2'b01, SWG_PAUSE = 2'b10} swg_state_t;
endpackage

// ### swg_interp.sv
`timescale 1ns/10ps
// linear interpolation: fromVal + (toVal - fromVal) * step / span
module swg_interp (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic go, // start one sample
  input wire logic [15:0] fromVal, // segment start level
  input wire logic [15:0] toVal, // segment end level
  input wire logic [31:0] step, // ticks elapsed, below span
  input wire logic [31:0] span, // segment length in ticks
  output logic [15:0] value, // interpolated level
  output logic done // one-cycle result strobe
);
  logic [47:0] quo_r;
  logic [32:0] rem_r;
  logic [5:0] cnt_r;
  logic [15:0] base_r;
  logic down_r;
  // slope magnitude and one restoring division step
  wire [15:0] diff = (toVal >= fromVal) ? toVal - fromVal : fromVal - toVal;
  wire [32:0] trial = {rem_r[31:0], quo_r[47]};
  wire fits = trial >= {1'b0, span};
  assign value = down_r ? base_r - quo_r[15:0] : base_r + quo_r[15:0];
  // shift-subtract divider, 48 steps per sample
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      quo_r <= 48'h0;
      rem_r <= 33'h0;
      cnt_r <= 6'h00;
      base_r <= 16'h0000;
      down_r <= 1'b0;
      done <= 1'b0;
    end else if (go) begin
      quo_r <= diff * step;
      rem_r <= 33'h0;
      cnt_r <= 6'h30;
      base_r <= fromVal;
      down_r <= toVal < fromVal;
      done <= 1'b0;
    end else begin
      done <= cnt_r == 6'h01;
      if (cnt_r != 6'h00) begin
        quo_r <= {quo_r[46:0], fits};
        rem_r <= fits ? trial - {1'b0, span} : trial;
        cnt_r <= cnt_r - 6'h01;
      end
    end
  end
  // result comes a fixed 49 cycles after launch
  divLatency_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    go |-> ##49 done) else $error("interpolation result late");
endmodule

// ### swg_top.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "swg_defines.svh"
// Contract
// - start while load off begins wave at once and switches the load on
// - stop command halts the wave only; load stays on with static values
// - on/off command halts the wave and switches the load off
// - alarm or trip halts the wave, switches load off, sets alarm status
// - the wave drives only the selected voltage or current set value
// - sine offset not below amplitude; offset plus amplitude within nominal
// - sine runs at one fixed frequency, at most 10000 Hz
// - triangle rises over t1 and falls over t2, each 0.1 ms to 36000 s
// - triangle base is offset, peak offset plus amplitude, within nominal
// - triangle period is t1 plus t2, repeating until stopped
// - rectangle holds top for t1, offset for t2, each 0.1 ms to 36000 s
// - rectangle period is t1 plus t2, duty is t1 over the period
// - trapezoid rises t1, holds top t2, falls t3, holds offset t4
// - trapezoid period is the sum of its four phases, repeating
// - engine-start profile only with voltage as target, never current
// - engine profile is five linear ramps, each with own levels and time
// - engine segment levels limited to zero through nominal voltage
// - engine segment parameters hold default test-pulse values after reset
// - engine profile repeats endlessly or a set count, at most 999
// - repeat count other than one inserts a pause after each cycle
// - no wave generation in slave mode or resistance regulation mode; the code only refuses a start, and a wave already running goes on
// - function and parameter changes only accepted while load is off
// - the two other set values stay constant and act as limits
// - a current-target wave always starts from zero amperes
module swg_top (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // bus stall
  input wire logic alarmIn, // unit alarm or protection trip
  input wire logic slaveMode, // unit is a slave
  input wire logic resistanceMode, // resistance regulation on
  output logic [15:0] setVolt, // voltage set value
  output logic [15:0] setCurr, // current set value
  output logic [15:0] setPower, // power set value
  output logic loadEnable, // load input on
  output logic alarmFlag, // sticky alarm status
  output logic genActive, // wave running
  output swg_pkg::swg_func_t activeFunc // selected function
);
  import swg_pkg::*;
  localparam int TICK_CYC = `SWG_TICK_CYC;
  localparam logic [79:0] SEG_LO_RST = `SWG_SEG_LO_RST;
  localparam logic [79:0] SEG_HI_RST = `SWG_SEG_HI_RST;
  localparam logic [159:0] SEG_T_RST = `SWG_SEG_T_RST;
  swg_func_t func_r;
  swg_tgt_t tgt_r;
  swg_state_t state_r;
  logic [15:0] ampl_r, offs_r, statU_r, statI_r, statP_r, waveVal_r;
  logic [13:0] freq_r;
  logic [31:0] tim_r [4];
  logic [15:0] segLo_r [5];
  logic [15:0] segHi_r [5];
  logic [31:0] segT_r [5];
  logic [9:0] rep_r, cycDone_r, tickCnt_r;
  logic [31:0] pause_r, k_r, phase_r, rdMux;
  logic [2:0] seg_r, segLast;
  logic running_r, loadOn_r, alarm_r;
  logic [15:0] segA, segB, ipVal;
  logic [31:0] segN;
  logic ipDone;

  // clamp helpers
  function automatic logic [15:0] lim16(input logic [31:0] v, input logic [15:0] m);
    return (v > {16'h0000, m}) ? m : v[15:0];
  endfunction
  function automatic logic [31:0] limT(input logic [31:0] v);
    if (v < 32'(`SWG_TMIN_TK)) return 32'(`SWG_TMIN_TK);
    return (v > 32'(`SWG_TMAX_TK)) ? 32'(`SWG_TMAX_TK) : v;
  endfunction

  // bus decode: one wait cycle, then the access is taken
  wire req = avs_read | avs_write;
  wire acc = req & ~avs_waitrequest;
  wire wrEn = avs_write & acc;
  wire [31:0] wd = avs_writedata;
  wire cfgOpen = ~loadOn_r;
  wire wrCmd = wrEn & (avs_address == `SWG_REG_CMD);
  wire wrPar = wrEn & cfgOpen;
  wire segHit = (avs_address >= `SWG_REG_SEG0) & (avs_address < `SWG_REG_SEGEND);
  wire [2:0] segIdx = 3'(avs_address[7:4] - 4'h4);
  wire [1:0] segFld = avs_address[3:2];
  wire [15:0] amplMax = `SWG_NOM - offs_r;
  wire [15:0] offsMax = `SWG_NOM - ampl_r;
  wire cfgOk = (wd[2:0] <= 3'b100) & ~((wd[2:0] == SWG_ENG) & wd[`SWG_CFG_TGT]);

  // commands and halts
  wire cmdStart = wrCmd & wd[`SWG_CMD_START];
  wire cmdStop = wrCmd & wd[`SWG_CMD_STOP];
  wire cmdOnOff = wrCmd & wd[`SWG_CMD_ONOFF];
  wire cmdClr = wrCmd & wd[`SWG_CMD_CLR];
  wire paramOk = (func_r != SWG_SINE) | (offs_r >= ampl_r);
  wire blocked = slaveMode | resistanceMode | ~paramOk;
  wire goStart = ~blocked & (cmdStart | (cmdOnOff & ~loadOn_r));
  wire haltOff = alarmIn | (cmdOnOff & loadOn_r);

  // sample tick and segment progress
  wire tick = running_r & (tickCnt_r == 10'(TICK_CYC - 1));
  wire inRun = state_r == SWG_RUN;
  wire segEnd = (k_r + 32'h1) >= segN;
  wire engLast = tick & inRun & (func_r == SWG_ENG) & (seg_r == 3'h4) & segEnd;
  wire profDone = engLast & (rep_r != 10'h0) & ((cycDone_r + 10'h1) >= rep_r);
  wire [15:0] topVal = offs_r + ampl_r;
  wire [31:0] phInc = 32'(freq_r * `SWG_PH_PER_HZ);

  // sine from a parabolic half-wave shape
  wire [15:0] ph = phase_r[30:15];
  wire [15:0] phN = ~ph;
  wire [31:0] parab = ph * phN;
  wire [16:0] sHalf = parab[31:15];
  wire [32:0] sMul = ampl_r * sHalf;
  wire [15:0] sAmp = sMul[30:15];
  wire [15:0] sineVal = phase_r[31] ? offs_r - sAmp : offs_r + sAmp;
  wire sineTick = tick & (func_r == SWG_SINE);
  wire pauseTick = tick & (state_r == SWG_PAUSE);
  wire ipGo = tick & inRun & (func_r != SWG_SINE);
  wire [15:0] staticI = (tgt_r == SWG_CURR) ? 16'h0000 : statI_r;

  // levels and length of the current segment
  always_comb begin
    segA = offs_r;
    segB = offs_r;
    segN = tim_r[seg_r[1:0]];
    segLast = 3'h1;
    unique case (func_r)
      SWG_TRI: begin
        segA = (seg_r == 3'h0) ? offs_r : topVal;
        segB = (seg_r == 3'h0) ? topVal : offs_r;
      end
      SWG_RECT: begin
        segA = (seg_r == 3'h0) ? topVal : offs_r;
        segB = segA;
      end
      SWG_TRAP: begin
        segLast = 3'h3;
        segA = ((seg_r == 3'h1) | (seg_r == 3'h2)) ? topVal : offs_r;
        segB = (seg_r <= 3'h1) ? topVal : offs_r;
      end
      SWG_ENG: begin
        segLast = 3'h4;
        segA = segLo_r[seg_r];
        segB = segHi_r[seg_r];
        segN = segT_r[seg_r];
      end
      default: begin
      end
    endcase
  end

  swg_interp u_interp (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .go(ipGo),
    .fromVal(segA),
    .toVal(segB),
    .step(k_r),
    .span(segN),
    .value(ipVal),
    .done(ipDone)
  );

  // read multiplexer
  always_comb begin
    rdMux = 32'h0;
    if (segHit) begin
      unique case (segFld)
        2'h0: rdMux = {16'h0000, segLo_r[segIdx]};
        2'h1: rdMux = {16'h0000, segHi_r[segIdx]};
        2'h2: rdMux = segT_r[segIdx];
        default: rdMux = 32'h0;
      endcase
    end else begin
      unique case (avs_address)
        `SWG_REG_CFG: rdMux = {28'h0, tgt_r, func_r};
        `SWG_REG_STAT: rdMux = {24'h0, seg_r, state_r, alarm_r, loadOn_r, running_r};
        `SWG_REG_AMPL: rdMux = {16'h0000, ampl_r};
        `SWG_REG_OFFS: rdMux = {16'h0000, offs_r};
        `SWG_REG_FREQ: rdMux = {18'h0, freq_r};
        `SWG_REG_T1: rdMux = tim_r[0];
        `SWG_REG_T2: rdMux = tim_r[1];
        `SWG_REG_T3: rdMux = tim_r[2];
        `SWG_REG_T4: rdMux = tim_r[3];
        `SWG_REG_SETU: rdMux = {16'h0000, statU_r};
        `SWG_REG_SETI: rdMux = {16'h0000, statI_r};
        `SWG_REG_SETP: rdMux = {16'h0000, statP_r};
        `SWG_REG_REP: rdMux = {22'h0, rep_r};
        `SWG_REG_PAUSE: rdMux = pause_r;
        default: rdMux = 32'h0;
      endcase
    end
  end

  // bus answer: waitrequest drops for one cycle per access
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (avs_read & avs_waitrequest) avs_readdata <= rdMux;
    end
  end

  // scalar parameters, locked while the load is on
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      func_r <= SWG_SINE;
      tgt_r <= SWG_VOLT;
      ampl_r <= 16'h0000;
      offs_r <= 16'h0000;
      freq_r <= `SWG_F_RST;
      for (int i = 0; i < 4; i++) tim_r[i] <= `SWG_T_RST;
      statU_r <= 16'h0000;
      statI_r <= 16'h0000;
      statP_r <= 16'h0000;
      rep_r <= `SWG_REP_RST;
      pause_r <= `SWG_T_RST;
    end else if (wrPar) begin
      unique case (avs_address)
        `SWG_REG_CFG: begin
          if (cfgOk) func_r <= swg_func_t'(wd[2:0]);
          if (cfgOk) tgt_r <= swg_tgt_t'(wd[`SWG_CFG_TGT]);
        end
        `SWG_REG_AMPL: ampl_r <= lim16(wd, amplMax);
        `SWG_REG_OFFS: offs_r <= lim16(wd, offsMax);
        `SWG_REG_FREQ: freq_r <= (wd == 32'h0) ? `SWG_FMIN : 14'(lim16(wd, 16'(`SWG_FMAX)));
        `SWG_REG_T1: tim_r[0] <= limT(wd);
        `SWG_REG_T2: tim_r[1] <= limT(wd);
        `SWG_REG_T3: tim_r[2] <= limT(wd);
        `SWG_REG_T4: tim_r[3] <= limT(wd);
        `SWG_REG_SETU: statU_r <= lim16(wd, `SWG_NOM);
        `SWG_REG_SETI: statI_r <= lim16(wd, `SWG_NOM);
        `SWG_REG_SETP: statP_r <= lim16(wd, `SWG_NOM);
        `SWG_REG_REP: rep_r <= 10'(lim16(wd, 16'(`SWG_REP_MAX)));
        `SWG_REG_PAUSE: pause_r <= limT(wd);
        default: begin
        end
      endcase
    end
  end

  // engine profile segments with default test-pulse values
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 5; i++) begin
        segLo_r[i] <= SEG_LO_RST[16*i +: 16];
        segHi_r[i] <= SEG_HI_RST[16*i +: 16];
        segT_r[i] <= SEG_T_RST[32*i +: 32];
      end
    end else if (wrPar & segHit) begin
      unique case (segFld)
        2'h0: segLo_r[segIdx] <= lim16(wd, `SWG_NOM);
        2'h1: segHi_r[segIdx] <= lim16(wd, `SWG_NOM);
        2'h2: segT_r[segIdx] <= limT(wd);
        default: begin
        end
      endcase
    end
  end

  // run, load and alarm control
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      running_r <= 1'b0;
      loadOn_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      if (alarmIn) alarm_r <= 1'b1;
      else if (cmdClr) alarm_r <= 1'b0;
      if (haltOff) begin
        running_r <= 1'b0;
        loadOn_r <= 1'b0;
      end else if (goStart) begin
        running_r <= 1'b1;
        loadOn_r <= 1'b1;
      end else if (cmdStop | profDone) begin
        running_r <= 1'b0;
      end
    end
  end

  // segment sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SWG_IDLE;
      seg_r <= 3'h0;
      k_r <= 32'h0;
      cycDone_r <= 10'h0;
      phase_r <= 32'h0;
      tickCnt_r <= 10'h0;
    end else if (goStart & ~haltOff) begin
      state_r <= SWG_RUN;
      seg_r <= 3'h0;
      k_r <= 32'h0;
      cycDone_r <= 10'h0;
      phase_r <= 32'h0;
      tickCnt_r <= 10'h0;
    end else if (~running_r) begin
      state_r <= SWG_IDLE;
    end else begin
      tickCnt_r <= tick ? 10'h0 : tickCnt_r + 10'h1;
      if (tick) phase_r <= phase_r + phInc;
      if (pauseTick) begin
        k_r <= ((k_r + 32'h1) >= pause_r) ? 32'h0 : k_r + 32'h1;
        if ((k_r + 32'h1) >= pause_r) state_r <= SWG_RUN;
      end else if (tick & segEnd) begin
        k_r <= 32'h0;
        seg_r <= (seg_r == segLast) ? 3'h0 : seg_r + 3'h1;
        if (engLast) cycDone_r <= cycDone_r + 10'h1;
        if (engLast & (rep_r != 10'h1)) state_r <= SWG_PAUSE;
      end else if (tick) begin
        k_r <= k_r + 32'h1;
      end
    end
  end

  // wave sample register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) waveVal_r <= 16'h0000;
    else if (goStart) waveVal_r <= (tgt_r == SWG_CURR) ? 16'h0000 : statU_r;
    else if (sineTick) waveVal_r <= sineVal;
    else if (pauseTick) waveVal_r <= statU_r;
    else if (ipDone & running_r & inRun) waveVal_r <= ipVal;
  end

  // output registers; the wave drives only its target
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      setVolt <= 16'h0000;
      setCurr <= 16'h0000;
      setPower <= 16'h0000;
      loadEnable <= 1'b0;
      alarmFlag <= 1'b0;
      genActive <= 1'b0;
      activeFunc <= SWG_SINE;
    end else begin
      setVolt <= (running_r & (tgt_r == SWG_VOLT)) ? waveVal_r : statU_r;
      setCurr <= (running_r & (tgt_r == SWG_CURR)) ? waveVal_r : staticI;
      setPower <= statP_r;
      loadEnable <= loadOn_r;
      alarmFlag <= alarm_r;
      genActive <= running_r;
      activeFunc <= func_r;
    end
  end

  // checks
  startLoad_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    goStart & ~haltOff |=> running_r && loadOn_r ##1 loadEnable && genActive)
    else $error("start did not enable load");
  stopKeeps_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmdStop & ~haltOff & ~goStart & loadOn_r |=> !running_r && loadOn_r)
    else $error("stop changed load state");
  onOffHalt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmdOnOff & loadOn_r |=> !running_r && !loadOn_r) else $error("on/off did not halt");
  alarmHalt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    alarmIn |=> (!running_r && !loadOn_r && alarm_r) ##1 !loadEnable)
    else $error("alarm did not halt");
  otherFixed_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    tgt_r == SWG_CURR |=> setVolt == $past(statU_r)) else $error("voltage not static");
  sumLimit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ({1'b0, ampl_r} + {1'b0, offs_r}) <= {1'b0, `SWG_NOM}) else $error("level over nominal");
  engVolt_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    func_r == SWG_ENG |-> tgt_r == SWG_VOLT) else $error("engine profile on current");
  repLimit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rep_r <= `SWG_REP_MAX) else $error("repeat count over limit");
  blocked_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (slaveMode | resistanceMode) & ~running_r |=> !running_r) else $error("blocked start ran");
  cfgLocked_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    wrEn & loadOn_r |=> $stable(func_r) && $stable(ampl_r) && $stable(offs_r))
    else $error("parameter changed with load on");
  restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    goStart & ~haltOff |=> seg_r == 3'h0 && k_r == 32'h0 && tickCnt_r == 10'h0)
    else $error("timers not restarted");
endmodule

// ### swg_load_model.sv
`timescale 1ns/10ps
// regulation stage on the far side of the set values
module swg_load_model (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic [15:0] setCurr, // commanded current
  input wire logic [15:0] setPower, // power limit
  input wire logic loadEnable, // load input on
  input wire logic tripReq, // bench asks for a trip
  output logic [15:0] drawn, // current actually drawn
  output logic tripOut // protection trip
);
  // drawn current is capped by the constant power set value
  assign drawn = !loadEnable ? 16'h0000 : ((setCurr > setPower) ? setPower : setCurr);
  // trip only while the load is on, as a real protection would
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tripOut <= 1'b0;
    end else begin
      tripOut <= tripReq & loadEnable;
    end
  end
endmodule

// ### setpoint_waveform_generator_tb.sv
`timescale 1ns/10ps
`include "swg_defines.svh"
module setpoint_waveform_generator_tb;
  import swg_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic slaveMode = 1'b0;
  logic resistanceMode = 1'b0;
  logic tripReq = 1'b0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic alarmIn;
  wire logic [15:0] setVolt;
  wire logic [15:0] setCurr;
  wire logic [15:0] setPower;
  wire logic [15:0] drawn;
  wire logic loadEnable;
  wire logic alarmFlag;
  wire logic genActive;
  swg_func_t activeFunc;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed = 24176;
  int n;
  logic [15:0] ampl;
  logic [15:0] hi;
  logic [31:0] expQ[$];

  swg_top i_swg_top (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .alarmIn(alarmIn),
    .slaveMode(slaveMode), .resistanceMode(resistanceMode), .setVolt(setVolt),
    .setCurr(setCurr), .setPower(setPower), .loadEnable(loadEnable),
    .alarmFlag(alarmFlag), .genActive(genActive), .activeFunc(activeFunc));
  swg_load_model i_swg_load_model (.sys_clk(sys_clk), .rstn(rstn), .setCurr(setCurr),
    .setPower(setPower), .loadEnable(loadEnable), .tripReq(tripReq), .drawn(drawn),
    .tripOut(alarmIn));

  // clock, 10 ns period
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      report_and_stop();
    end
  end

  // read results are compared with the oldest note
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0) begin
      chk(avs_readdata, expQ.pop_front());
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask

  task edges(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // wait for a voltage level, n returns the cycles spent
  task waitv(input logic [15:0] e, input int lim);
    n = 0;
    while (setVolt !== e && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // main sequence
  initial begin
    edges(20);
    rstn <= 1'b1;
    rd(`SWG_REG_T1, 32'h0000000A);
    rd(`SWG_REG_FREQ, 32'h00000001);
    rd(`SWG_REG_REP, 32'h00000001);
    rd(`SWG_REG_SEG0 + 8'h08, 32'h000001F4);
    rd(8'h3C, 32'h00000000);
    rd(`SWG_REG_STAT, 32'h00000000);
    $display("test reset done");
    ampl = 16'h0010 + 16'($random(seed) & 32'h000000FF);
    hi = 16'h0200 + ampl;
    wr(`SWG_REG_CFG, 32'({SWG_VOLT, SWG_RECT}));
    wr(`SWG_REG_AMPL, 32'(ampl));
    wr(`SWG_REG_OFFS, 32'h00000200);
    wr(`SWG_REG_SETU, 32'h00000250);
    wr(`SWG_REG_SETP, 32'h00000500);
    wr(`SWG_REG_CMD, 32'h00000001);
    edges(2);
    chk(32'(genActive), 32'h1);
    chk(32'(loadEnable), 32'h1);
    chk(32'(activeFunc), 32'(SWG_RECT));
    waitv(hi, 25000);
    chk(32'(setVolt), 32'(hi));
    waitv(16'h0200, 12000);
    chk(32'(n >= 9900 && n <= 10100), 32'h1);
    waitv(hi, 12000);
    chk(32'(n >= 9900 && n <= 10100), 32'h1);
    chk(32'(setPower), 32'h00000500);
    wr(`SWG_REG_AMPL, 32'h00000001);
    rd(`SWG_REG_AMPL, 32'(ampl));
    wr(`SWG_REG_CMD, 32'h00000002);
    edges(2);
    chk(32'(genActive), 32'h0);
    chk(32'(loadEnable), 32'h1);
    waitv(16'h0250, 1100);
    chk(32'(setVolt), 32'h00000250);
    wr(`SWG_REG_CMD, 32'h00000004);
    edges(2);
    chk(32'(loadEnable), 32'h0);
    $display("test rectangle done");
    wr(`SWG_REG_CFG, 32'({SWG_CURR, SWG_TRAP}));
    wr(`SWG_REG_CMD, 32'h00000001);
    edges(2);
    chk(32'(setCurr), 32'h00000000);
    edges(2500);
    chk(32'(setCurr != 16'h0000), 32'h1);
    chk(32'(setVolt), 32'h00000250);
    tripReq <= 1'b1;
    edges(6);
    chk(32'(alarmFlag), 32'h1);
    chk(32'(loadEnable), 32'h0);
    chk(32'(genActive), 32'h0);
    chk(32'(drawn), 32'h0);
    tripReq <= 1'b0;
    wr(`SWG_REG_CMD, 32'h00000008);
    edges(2);
    chk(32'(alarmFlag), 32'h0);
    $display("test alarm done");
    wr(`SWG_REG_CFG, 32'({SWG_CURR, SWG_ENG}));
    rd(`SWG_REG_CFG, 32'({SWG_CURR, SWG_TRAP}));
    slaveMode <= 1'b1;
    wr(`SWG_REG_CMD, 32'h00000001);
    edges(3);
    chk(32'(genActive), 32'h0);
    slaveMode <= 1'b0;
    resistanceMode <= 1'b1;
    wr(`SWG_REG_CMD, 32'h00000001);
    edges(3);
    chk(32'(genActive), 32'h0);
    resistanceMode <= 1'b0;
    $display("test refusals done");
    wr(`SWG_REG_CFG, 32'({SWG_VOLT, SWG_ENG}));
    wr(`SWG_REG_SEG0 + 8'h08, 32'h00000001);
    rd(`SWG_REG_SEG0 + 8'h08, 32'(`SWG_TMIN_TK));
    wr(`SWG_REG_CMD, 32'h00000001);
    waitv(16'h1770, 3000);
    chk(32'(setVolt), 32'h00001770);
    waitv(16'h0960, 12000);
    chk(32'(n >= 9900 && n <= 10100), 32'h1);
    wr(`SWG_REG_CMD, 32'h00000004);
    $display("test engine done");
    edges(4);
    report_and_stop();
  end
endmodule
